// ---- src/mpcs_pkg.sv ----
// constants, field layout and types of the carrier-synchronous motor pwm block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package mpcs_pkg;

	// ------------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CARRIER_CYCLE_NS = 125000;
	localparam int unsigned CARRIER_HALF_CYC = CARRIER_CYCLE_NS / CLK_PERIOD_NS / 2;
	localparam int unsigned DEAD_TIME_NS = 2500;
	localparam int unsigned DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EXC_FREQ_HZ = 10000;
	localparam int unsigned EXC_PERIOD_NS = 1000000000 / EXC_FREQ_HZ;
	localparam int unsigned EXC_HALF_CYC = EXC_PERIOD_NS / CLK_PERIOD_NS / 2;

	// ------------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------------
	localparam int NPH = 3;
	localparam int CNT_W = 16;
	localparam int DT_W = 8;
	localparam int EXC_W = 16;
	localparam int ADC_W = 12;
	localparam int ANG_W = 16;
	localparam int NSTAT = 3;
	localparam int ADDR_W = 8;

	// ------------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CMP_U = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMP_V = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CMP_W = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_CUR_V = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_CUR_W = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_CUR_U = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_ANGLE = 8'h2C;

	// ------------------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EXC_BIT = 1;
	localparam int COUNT_DIR_BIT = 16;
	localparam int ST_TROUGH = 0;
	localparam int ST_ANGLE = 1;
	localparam int ST_SCAN = 2;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [NSTAT-1:0] MASK_RST = 3'h0;

	// scan channels in conversion order
	localparam logic [1:0] CH_V = 2'h0;
	localparam logic [1:0] CH_W = 2'h1;
	localparam logic [1:0] CH_U = 2'h2;

	typedef enum logic [2:0] {
		MPCS_SCAN_IDLE = 3'b001,
		MPCS_SCAN_REQ = 3'b010,
		MPCS_SCAN_WAIT = 3'b100
	} mpcs_scan_t;

endpackage

// ---- src/mpcs_deadband.sv ----
// dead-time insertion for one complementary phase pair
`timescale 1ns/10ps
module mpcs_deadband (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic raw,
	output logic hi,
	output logic lo
);
	import mpcs_pkg::*;

	localparam logic [DT_W-1:0] DEAD = DEAD_CYC[DT_W-1:0];

	logic raw_q_ff;
	logic [DT_W-1:0] cnt_ff;
	logic hi_ff;
	logic lo_ff;
	wire changed = raw != raw_q_ff;
	wire settled = (cnt_ff == DEAD) && !changed;
	wire [DT_W-1:0] nxt_cnt = (changed || !en) ? '0 :
		(cnt_ff == DEAD) ? cnt_ff : cnt_ff + 1'b1;
	// turn-off is immediate, turn-on waits the full interval on both sides
	wire nxt_hi = en && raw && settled;
	wire nxt_lo = en && !raw && settled;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_q_ff <= 1'b0;
			cnt_ff <= '0;
			hi_ff <= 1'b0;
			lo_ff <= 1'b0;
		end else begin
			raw_q_ff <= raw;
			cnt_ff <= nxt_cnt;
			hi_ff <= nxt_hi;
			lo_ff <= nxt_lo;
		end
	end

	assign hi = hi_ff;
	assign lo = lo_ff;

endmodule

// ---- src/mpcs_top.sv ----
// carrier-synchronous three-phase pwm with trough triggers, scan sequencer and apb registers
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
module mpcs_top #(
	parameter int unsigned CARRIER_HALF = mpcs_pkg::CARRIER_HALF_CYC,
	parameter int unsigned EXC_HALF = mpcs_pkg::EXC_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mpcs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [mpcs_pkg::NPH-1:0] pwm_upper,
	output logic [mpcs_pkg::NPH-1:0] pwm_lower,
	output logic conv_trigger,
	output logic conv_start,
	output logic [1:0] conv_channel,
	input wire logic conv_done,
	input wire logic [mpcs_pkg::ADC_W-1:0] conv_data,
	input wire logic [mpcs_pkg::ANG_W-1:0] resolver_angle,
	output logic angle_dma_req,
	output logic resolver_excite,
	output logic irq
);
	import mpcs_pkg::*;

	localparam logic [CNT_W-1:0] HALF_RST = CARRIER_HALF[CNT_W-1:0];
	localparam logic [EXC_W-1:0] EXC_LAST = EXC_W'(EXC_HALF - 1);

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	logic [1:0] ctrl_ff;
	logic [CNT_W-1:0] period_sh_ff;
	logic [CNT_W-1:0] period_act_ff;
	logic [CNT_W-1:0] cmp_sh_ff [NPH];
	logic [CNT_W-1:0] cmp_act_ff [NPH];
	logic [NSTAT-1:0] status_ff;
	logic [NSTAT-1:0] mask_ff;
	logic [ADC_W-1:0] cur_v_ff;
	logic [ADC_W-1:0] cur_w_ff;
	logic [ADC_W-1:0] cur_u_ff;
	logic [ANG_W-1:0] angle_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic dir_up_ff;
	logic [NPH-1:0] raw_ff;
	logic conv_trig_ff;
	logic angle_req_ff;
	logic angle_done_ff;
	logic scan_end_ff;
	logic conv_start_ff;
	logic [1:0] chan_ff;
	mpcs_scan_t scan_ff;
	logic [EXC_W-1:0] exc_cnt_ff;
	logic exc_ff;
	logic irq_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	// ------------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------------
	wire run = ctrl_ff[CTRL_RUN_BIT];
	// one wait state: pready rises in the second access cycle
	wire access = psel && penable && pready_ff;
	wire wr = access && pwrite;
	wire sel_ctrl = paddr == OFS_CTRL;
	wire sel_period = paddr == OFS_PERIOD;
	wire sel_cmp_u = paddr == OFS_CMP_U;
	wire sel_cmp_v = paddr == OFS_CMP_V;
	wire sel_cmp_w = paddr == OFS_CMP_W;
	wire sel_status = paddr == OFS_STATUS;
	wire sel_mask = paddr == OFS_MASK;
	wire sel_count = paddr == OFS_COUNT;
	wire sel_cur_v = paddr == OFS_CUR_V;
	wire sel_cur_w = paddr == OFS_CUR_W;
	wire sel_cur_u = paddr == OFS_CUR_U;
	wire sel_angle = paddr == OFS_ANGLE;
	wire mapped = sel_ctrl || sel_period || sel_cmp_u || sel_cmp_v || sel_cmp_w
		|| sel_status || sel_mask || sel_count || sel_cur_v || sel_cur_w
		|| sel_cur_u || sel_angle;
	wire [NPH-1:0] sel_cmp = {sel_cmp_w, sel_cmp_v, sel_cmp_u};
	wire nxt_pready = psel && penable && !pready_ff;
	wire nxt_pslverr = nxt_pready && !mapped;

	wire [31:0] rd_data =
		sel_ctrl ? {30'h0, ctrl_ff} :
		sel_period ? {16'h0, period_sh_ff} :
		sel_cmp_u ? {16'h0, cmp_sh_ff[0]} :
		sel_cmp_v ? {16'h0, cmp_sh_ff[1]} :
		sel_cmp_w ? {16'h0, cmp_sh_ff[2]} :
		sel_status ? {29'h0, status_ff} :
		sel_mask ? {29'h0, mask_ff} :
		sel_count ? {15'h0, dir_up_ff, cnt_ff} :
		sel_cur_v ? {20'h0, cur_v_ff} :
		sel_cur_w ? {20'h0, cur_w_ff} :
		sel_cur_u ? {20'h0, cur_u_ff} :
		sel_angle ? {16'h0, angle_ff} :
		32'h0;
	wire [31:0] nxt_prdata = (nxt_pready && !pwrite) ? rd_data : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	// ------------------------------------------------------------------------
	// control, period and mask registers
	// ------------------------------------------------------------------------
	wire [1:0] nxt_ctrl = (wr && sel_ctrl) ? pwdata[1:0] : ctrl_ff;
	wire [CNT_W-1:0] nxt_period_sh = (wr && sel_period) ? pwdata[CNT_W-1:0] : period_sh_ff;
	wire [NSTAT-1:0] nxt_mask = (wr && sel_mask) ? pwdata[NSTAT-1:0] : mask_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
			period_sh_ff <= HALF_RST;
			mask_ff <= MASK_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
			period_sh_ff <= nxt_period_sh;
			mask_ff <= nxt_mask;
		end
	end

	// ------------------------------------------------------------------------
	// triangular carrier
	// ------------------------------------------------------------------------
	// idle parks at zero counting down, so the first enabled cycle is a trough
	wire trough = run && !dir_up_ff && (cnt_ff == '0);
	// a period of zero would stall the carrier; it is treated as one
	wire at_peak = dir_up_ff && (cnt_ff >= period_act_ff);
	wire [CNT_W-1:0] nxt_cnt = !run ? '0 :
		trough ? cnt_ff + 1'b1 :
		at_peak ? cnt_ff - 1'b1 :
		dir_up_ff ? cnt_ff + 1'b1 : cnt_ff - 1'b1;
	wire nxt_dir_up = !run ? 1'b0 :
		trough ? 1'b1 :
		at_peak ? 1'b0 : dir_up_ff;
	// period loads only at the trough, never within a half-cycle
	wire [CNT_W-1:0] nxt_period_act = trough ? period_sh_ff : period_act_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			dir_up_ff <= 1'b0;
			period_act_ff <= HALF_RST;
		end else begin
			cnt_ff <= nxt_cnt;
			dir_up_ff <= nxt_dir_up;
			period_act_ff <= nxt_period_act;
		end
	end

	// ------------------------------------------------------------------------
	// per-phase compare, shadow reload and dead time
	// ------------------------------------------------------------------------
	genvar ph;
	generate
		for (ph = 0; ph < NPH; ph++) begin : g_phase
			wire [CNT_W-1:0] nxt_cmp_sh = (wr && sel_cmp[ph]) ?
				pwdata[CNT_W-1:0] : cmp_sh_ff[ph];
			wire [CNT_W-1:0] nxt_cmp_act = trough ?
				cmp_sh_ff[ph] : cmp_act_ff[ph];
			// every phase compares every cycle while run is set; a compare of zero keeps the upper side off
			wire nxt_raw = run && (cmp_act_ff[ph] > cnt_ff);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_sh_ff[ph] <= CMP_RST;
					cmp_act_ff[ph] <= CMP_RST;
					raw_ff[ph] <= 1'b0;
				end else begin
					cmp_sh_ff[ph] <= nxt_cmp_sh;
					cmp_act_ff[ph] <= nxt_cmp_act;
					raw_ff[ph] <= nxt_raw;
				end
			end

			mpcs_deadband u_dead (
				.pclk(pclk),
				.presetn(presetn),
				.en(run),
				.raw(raw_ff[ph]),
				.hi(pwm_upper[ph]),
				.lo(pwm_lower[ph])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// trough events: converter trigger and angle transfer
	// ------------------------------------------------------------------------
	wire nxt_conv_trig = trough;
	wire nxt_angle_req = trough;
	// the copy lands one cycle after the request, in the same cycle as the completion flag
	wire [ANG_W-1:0] nxt_angle = angle_req_ff ? resolver_angle : angle_ff;
	wire nxt_angle_done = angle_req_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_trig_ff <= 1'b0;
			angle_req_ff <= 1'b0;
			angle_ff <= '0;
			angle_done_ff <= 1'b0;
		end else begin
			conv_trig_ff <= nxt_conv_trig;
			angle_req_ff <= nxt_angle_req;
			angle_ff <= nxt_angle;
			angle_done_ff <= nxt_angle_done;
		end
	end

	// ------------------------------------------------------------------------
	// scan group sequencer
	// ------------------------------------------------------------------------
	// a trigger during a scan is dropped: one scan per accepted trigger
	wire last_chan = chan_ff == CH_U;
	wire take_result = (scan_ff == MPCS_SCAN_WAIT) && conv_done;
	mpcs_scan_t nxt_scan;
	logic [1:0] nxt_chan;
	logic nxt_conv_start;
	logic nxt_scan_end;

	always_comb begin
		nxt_scan = scan_ff;
		nxt_chan = chan_ff;
		nxt_conv_start = 1'b0;
		nxt_scan_end = 1'b0;
		case (scan_ff)
			MPCS_SCAN_IDLE: begin
				if (conv_trig_ff) begin
					nxt_scan = MPCS_SCAN_REQ;
					nxt_chan = CH_V;
				end
			end
			MPCS_SCAN_REQ: begin
				nxt_conv_start = 1'b1;
				nxt_scan = MPCS_SCAN_WAIT;
			end
			MPCS_SCAN_WAIT: begin
				if (conv_done) begin
					if (last_chan) begin
						nxt_scan = MPCS_SCAN_IDLE;
						nxt_scan_end = 1'b1;
					end else begin
						nxt_scan = MPCS_SCAN_REQ;
						nxt_chan = chan_ff + 2'h1;
					end
				end
			end
			default: begin
				nxt_scan = MPCS_SCAN_IDLE;
				nxt_chan = CH_V;
			end
		endcase
	end

	wire [ADC_W-1:0] nxt_cur_v = (take_result && chan_ff == CH_V) ? conv_data : cur_v_ff;
	wire [ADC_W-1:0] nxt_cur_w = (take_result && chan_ff == CH_W) ? conv_data : cur_w_ff;
	wire [ADC_W-1:0] nxt_cur_u = (take_result && chan_ff == CH_U) ? conv_data : cur_u_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_ff <= MPCS_SCAN_IDLE;
			chan_ff <= CH_V;
			conv_start_ff <= 1'b0;
			scan_end_ff <= 1'b0;
			cur_v_ff <= '0;
			cur_w_ff <= '0;
			cur_u_ff <= '0;
		end else begin
			scan_ff <= nxt_scan;
			chan_ff <= nxt_chan;
			conv_start_ff <= nxt_conv_start;
			scan_end_ff <= nxt_scan_end;
			cur_v_ff <= nxt_cur_v;
			cur_w_ff <= nxt_cur_w;
			cur_u_ff <= nxt_cur_u;
		end
	end

	// ------------------------------------------------------------------------
	// resolver excitation
	// ------------------------------------------------------------------------
	wire exc_en = ctrl_ff[CTRL_EXC_BIT];
	wire exc_wrap = exc_cnt_ff == EXC_LAST;
	wire [EXC_W-1:0] nxt_exc_cnt = (!exc_en || exc_wrap) ? '0 : exc_cnt_ff + 1'b1;
	wire nxt_exc = !exc_en ? 1'b0 : (exc_wrap ? !exc_ff : exc_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_cnt_ff <= '0;
			exc_ff <= 1'b0;
		end else begin
			exc_cnt_ff <= nxt_exc_cnt;
			exc_ff <= nxt_exc;
		end
	end

	// ------------------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------------------
	wire [NSTAT-1:0] stat_set;
	assign stat_set[ST_TROUGH] = conv_trig_ff;
	assign stat_set[ST_ANGLE] = angle_done_ff;
	assign stat_set[ST_SCAN] = scan_end_ff;
	wire [NSTAT-1:0] stat_clr = (wr && sel_status) ? pwdata[NSTAT-1:0] : '0;
	// a new event wins over a clear in the same cycle
	wire [NSTAT-1:0] nxt_status = (status_ff & ~stat_clr) | stat_set;
	wire nxt_irq = |(nxt_status & nxt_mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_ff <= nxt_irq;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign conv_trigger = conv_trig_ff;
	assign conv_start = conv_start_ff;
	assign conv_channel = chan_ff;
	assign angle_dma_req = angle_req_ff;
	assign resolver_excite = exc_ff;
	assign irq = irq_ff;

endmodule

// ---- verification/mpcs_top_properties.sv ----
// concurrent checks on the ports of the carrier-synchronous pwm block
`timescale 1ns/10ps
module mpcs_top_properties
	import mpcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [mpcs_pkg::NPH-1:0] pwm_upper,
	input wire logic [mpcs_pkg::NPH-1:0] pwm_lower,
	input wire logic conv_trigger,
	input wire logic conv_start,
	input wire logic [1:0] conv_channel,
	input wire logic conv_done,
	input wire logic angle_dma_req
);
	// ------------------------------------------------------------------------
	// helper: cycles with both outputs of phase u low, saturating
	// ------------------------------------------------------------------------
	logic [8:0] gap_ff;
	wire both_low = !pwm_upper[0] && !pwm_lower[0];
	wire [8:0] nxt_gap = !both_low ? 9'h000 : ((gap_ff == 9'h1FF) ? gap_ff : gap_ff + 9'h001);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_ff <= 9'h000;
		end else begin
			gap_ff <= nxt_gap;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------------
	property p_no_overlap;
		(pwm_upper & pwm_lower) == 3'h0;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("upper and lower high together");
	// one cycle of slack for the registered compare stage
	property p_dead_gap;
		$rose(pwm_upper[0]) || $rose(pwm_lower[0]) |-> gap_ff >= 9'h0F9;
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("turn-on without dead time");
	property p_trig_pulse;
		conv_trigger |=> !conv_trigger;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");
	property p_trig_dma;
		conv_trigger == angle_dma_req;
	endproperty
	a_trig_dma: assert property (p_trig_dma) else $error("angle request not with trigger");
	property p_start_cause;
		conv_start |-> $past(conv_trigger, 2) || $past(conv_done, 2);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("conversion start without cause");
	property p_first_chan;
		conv_start && $past(conv_trigger, 2) |-> conv_channel == CH_V;
	endproperty
	a_first_chan: assert property (p_first_chan) else $error("scan does not begin on channel 0");
	property p_chan_order;
		conv_start && !$past(conv_trigger, 2) |-> conv_channel == $past(conv_channel, 2) + 2'h1;
	endproperty
	a_chan_order: assert property (p_chan_order) else $error("scan channel out of order");
	property p_start_pulse;
		conv_start |=> !conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start wider than one cycle");
endmodule

bind mpcs_top mpcs_top_properties u_props (.pclk(pclk), .presetn(presetn),
	.pwm_upper(pwm_upper), .pwm_lower(pwm_lower), .conv_trigger(conv_trigger),
	.conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
	.angle_dma_req(angle_dma_req));

// ---- verification/mpcs_conv_model.sv ----
// behavioural current-sense converter and resolver angle source
`timescale 1ns/10ps
module mpcs_conv_model
	import mpcs_pkg::*;
#(
	parameter int DELAY = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input wire logic [1:0] conv_channel,
	output logic conv_done,
	output logic [mpcs_pkg::ADC_W-1:0] conv_data,
	output logic [mpcs_pkg::ANG_W-1:0] resolver_angle
);
	logic busy_ff;
	logic [3:0] cnt_ff;
	logic [1:0] ch_ff;
	logic [ADC_W-1:0] res_ff;
	logic [ANG_W-1:0] angle_ff;
	// data bus shows the inverse outside the done cycle so a late sample fails
	assign conv_data = conv_done ? res_ff : ~res_ff;
	assign resolver_angle = angle_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			ch_ff <= 2'h0;
			res_ff <= 12'h000;
			angle_ff <= 16'h2468;
			conv_done <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (conv_start) begin
				busy_ff <= 1'b1;
				cnt_ff <= 4'(DELAY);
				ch_ff <= conv_channel;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
				if (cnt_ff == 4'h1) begin
					busy_ff <= 1'b0;
					conv_done <= 1'b1;
					res_ff <= 12'h5A0 + 12'(ch_ff);
					// angle moves only between scans, never near a capture
					if (ch_ff == CH_U) begin
						angle_ff <= angle_ff + 16'h1111;
					end
				end
			end
		end
	end
endmodule

// ---- verification/test_motor_pwm_carrier_sync.sv ----
// register-level testbench of the carrier-synchronous pwm block
`timescale 1ns/10ps
module test_motor_pwm_carrier_sync;
	import mpcs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_trigger, conv_start;
	logic conv_done, angle_dma_req, resolver_excite, irq, e;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [NPH-1:0] pwm_upper, pwm_lower;
	logic [1:0] conv_channel;
	logic [ADC_W-1:0] conv_data;
	logic [ANG_W-1:0] resolver_angle;
	int n_fail, samples_checked, cyc, last_trig, last_gap, w;

	mpcs_top #(.CARRIER_HALF(20), .EXC_HALF(4)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_upper(pwm_upper),
		.pwm_lower(pwm_lower), .conv_trigger(conv_trigger), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data),
		.resolver_angle(resolver_angle), .angle_dma_req(angle_dma_req),
		.resolver_excite(resolver_excite), .irq(irq));
	mpcs_conv_model #(.DELAY(3)) u_model (.pclk(pclk), .presetn(presetn),
		.conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
		.conv_data(conv_data), .resolver_angle(resolver_angle));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ------------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			n_fail++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask
	task automatic wait_trig;
		int n;
		n = 0;
		@(posedge pclk);
		while (conv_trigger !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (conv_trigger !== 1'b1) begin
			n_fail++;
		end
		// let the gap bookkeeping of this edge land first
		#1;
	endtask
	function automatic logic sig(int idx, bit up);
		if (idx == 3) begin
			return resolver_excite;
		end
		return up ? pwm_upper[idx] : pwm_lower[idx];
	endfunction
	task automatic width(input int idx, input bit up);
		int n;
		n = 0;
		w = 0;
		while (sig(idx, up) === 1'b1 && n < 3000) begin @(posedge pclk); n++; end
		while (sig(idx, up) !== 1'b1 && n < 6000) begin @(posedge pclk); n++; end
		while (sig(idx, up) === 1'b1 && w < 3000) begin @(posedge pclk); w++; end
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (conv_trigger === 1'b1) begin
			last_gap = cyc - last_trig;
			last_trig = cyc;
		end
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{n_fail, samples_checked, cyc, last_trig, last_gap} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
		rd_chk(OFS_PERIOD, 32'h14, "period reset");
		rd_chk(OFS_CMP_U, 32'h0, "cmp u reset");
		rd_chk(OFS_MASK, 32'h0, "mask reset");
		rd_chk(OFS_STATUS, 32'h0, "status reset");
		rd_chk(OFS_COUNT, 32'h0, "count idle");
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped error", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		$display("test reset_map done");
		// software sets run, period and compare values; carrier and reloads are hardware
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_trig();
		wait_trig();
		check("carrier gap default", 32'(last_gap), 32'h28);
		apb(1'b1, OFS_PERIOD, 32'h258);
		apb(1'b1, OFS_CMP_U, 32'h190);
		apb(1'b1, OFS_CMP_V, 32'h12C);
		apb(1'b1, OFS_CMP_W, 32'h0);
		wait_trig();
		check("gap before reload", 32'(last_gap), 32'h28);
		wait_trig();
		check("gap after reload", 32'(last_gap), 32'h4B0);
		$display("test carrier done");
		width(0, 1'b1);
		check("u upper width", {31'h0, w >= 546 && w <= 552}, 32'h1);
		width(0, 1'b0);
		check("u lower width", {31'h0, w >= 147 && w <= 153}, 32'h1);
		width(1, 1'b1);
		check("v upper width", {31'h0, w >= 346 && w <= 352}, 32'h1);
		check("w upper idle", {31'h0, pwm_upper[2]}, 32'h0);
		check("w lower on", {31'h0, pwm_lower[2]}, 32'h1);
		$display("test pwm done");
		wait_trig();
		repeat (40) @(posedge pclk);
		rd_chk(OFS_CUR_V, 32'h5A0, "current v");
		rd_chk(OFS_CUR_W, 32'h5A1, "current w");
		rd_chk(OFS_CUR_U, 32'h5A2, "current u");
		rd_chk(OFS_ANGLE, {16'h0, resolver_angle - 16'h1111}, "angle copy");
		rd_chk(OFS_STATUS, 32'h7, "status events");
		check("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, OFS_MASK, 32'h4);
		repeat (2) @(posedge pclk);
		check("irq scan end", {31'h0, irq}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h4);
		repeat (2) @(posedge pclk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		rd_chk(OFS_STATUS, 32'h3, "status w1c");
		apb(1'b1, OFS_STATUS, 32'h3);
		apb(1'b1, OFS_MASK, 32'h1);
		wait_trig();
		repeat (6) @(posedge pclk);
		check("irq trough", {31'h0, irq}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h7);
		apb(1'b1, OFS_MASK, 32'h2);
		wait_trig();
		repeat (6) @(posedge pclk);
		check("irq angle done", {31'h0, irq}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h7);
		repeat (2) @(posedge pclk);
		check("irq angle clear", {31'h0, irq}, 32'h0);
		$display("test scan_irq done");
		apb(1'b1, OFS_CTRL, 32'h3);
		width(3, 1'b1);
		check("excite half period", 32'(w), 32'h4);
		$display("test excite done");
		complete_run();
	end
endmodule
